/* File: bsf_pkg.sv */
// Constants, field layout and register map of the sequencer flow-op engine
package bsf_pkg;

    // Timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int US_NS         = 1000;
    localparam int CYC_PER_US    = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PRE_W         = 8;
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(CYC_PER_US - 1);

    // Instruction word layout
    localparam int OPC_MSB   = 14;
    localparam int OPC_LSB   = 10;
    localparam int CC_SENSE  = 4;
    localparam int CC_SEL_MSB = 3;
    localparam int IRQ_PAT_W = 4;
    localparam int WORD_W    = 16;

    // Op codes
    localparam logic [4:0] OP_CALL    = 5'h03;
    localparam logic [4:0] OP_RETURN  = 5'h04;
    localparam logic [4:0] OP_IRQ     = 5'h06;
    localparam logic [4:0] OP_STOP    = 5'h07;
    localparam logic [4:0] OP_PAUSE   = 5'h08;
    localparam logic [4:0] OP_FRWAIT  = 5'h09;
    localparam logic [4:0] OP_FRCMP   = 5'h0A;
    localparam logic [4:0] OP_MSGCMP  = 5'h0B;
    localparam logic [4:0] OP_FLAGUPD = 5'h0C;

    // Instruction memory and call stack
    localparam int RAM_DEPTH   = 64;
    localparam int PTR_W       = 6;
    localparam int STACK_DEPTH = 4;
    localparam int DEPTH_W     = 3;
    localparam logic [PTR_W-1:0] PTR_STEP = 6'h02;

    // Register map (byte addresses)
    localparam int ADDR_W = 9;
    localparam logic [ADDR_W-1:0] OFF_CTRL     = 9'h000;
    localparam logic [ADDR_W-1:0] OFF_STATUS   = 9'h004;
    localparam logic [ADDR_W-1:0] OFF_INT_STAT = 9'h008;
    localparam logic [ADDR_W-1:0] OFF_INT_MASK = 9'h00C;
    localparam logic [ADDR_W-1:0] OFF_GPFLAGS  = 9'h010;
    localparam logic [ADDR_W-1:0] OFF_START    = 9'h014;
    localparam logic [ADDR_W-1:0] RAM_BASE     = 9'h100;

    // Interrupt status layout
    localparam int INT_W        = 6;
    localparam int INT_STACK    = 0;
    localparam int INT_STOP     = 1;
    localparam int INT_SEQ_LSB  = 2;
    localparam logic [INT_W-1:0]  INT_MASK_RST = 6'h00;
    localparam logic [PTR_W-1:0]  START_RST    = 6'h00;

    // Status register layout
    localparam int ST_RUN    = 0;
    localparam int ST_STOP   = 1;
    localparam int ST_WAIT   = 2;
    localparam int ST_DEPTH  = 4;
    localparam int ST_PTR    = 8;

    typedef enum logic [2:0] {
        S_IDLE,
        S_FETCH_OP,
        S_FETCH_PRM,
        S_EXEC,
        S_DELAY,
        S_FRWAIT
    } bsf_state_t;

endpackage

/* File: bsf_sequencer.sv */
// Sequencer flow-control, interrupt, timing and flag instructions with AHB-Lite register access
//
// Overview of operation
// - Instruction is op word plus parameter; op word has op code and condition field.
// - False condition: do nothing, step pointer to next op/parameter pair.
// - Call pushes next op address and jumps to parameter address.
// - Call stack holds at most four return addresses.
// - Return pops stack top and resumes there; parameter ignored.
// - Interrupt request uses only parameter low four bits as pattern.
// - Pattern bits set sequencer interrupt bits 5..2 of interrupt status.
// - All-zero pattern sets no bit and raises no interrupt.
// - Stop halts execution until host issues a new start.
// - Pause waits parameter microseconds before next fetch; none when false.
// - Pause is timed by the time-to-next-message timer.
// - Frame wait stalls until frame time counter is zero.
// - Frame compare always runs, updates less-than and equal flags.
// - Message compare always runs, compares against frame time counter.
// - Only flags 0 and 1 change by compares: less-than and equal.
// - Flag update always runs; flag n uses parameter bits n and n+8.
// - Control 00 keeps flag, 01 sets it, 10 clears it.
//
// The AHB-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
module bsf_sequencer (
    // Clock, reset, enable
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic                       ce,
    // AHB-Lite slave
    input  wire logic                       hsel,
    input  wire logic [31:0]                haddr,
    input  wire logic [1:0]                 htrans,
    input  wire logic                       hwrite,
    input  wire logic [2:0]                 hsize,
    input  wire logic [31:0]                hwdata,
    input  wire logic                       hready,
    output logic                            hreadyout,
    output logic                            hresp,
    output logic [31:0]                     hrdata,
    // Rest of the unit
    input  wire logic [bsf_pkg::WORD_W-1:0] frame_time_i,
    input  wire logic [7:0]                 msg_cond_i,
    // Interrupt
    output logic                            irq
);
    import bsf_pkg::*;

    bsf_state_t              state_q;
    logic [WORD_W-1:0]       ram_q [RAM_DEPTH];
    logic [PTR_W-1:0]        ptr_q;
    logic [WORD_W-1:0]       opw_q;
    logic [WORD_W-1:0]       prm_q;
    logic [PTR_W-1:0]        stack_q [STACK_DEPTH];
    logic [DEPTH_W-1:0]      depth_q;
    logic                    stopped_q;
    logic [WORD_W-1:0]       tnm_q;
    logic [PRE_W-1:0]        pre_q;
    logic [7:0]              gp_q;
    logic [INT_W-1:0]        int_stat_q;
    logic [INT_W-1:0]        int_mask_q;
    logic [PTR_W-1:0]        start_addr_q;
    logic                    wr_q;
    logic [ADDR_W-1:0]       waddr_q;
    logic                    irq_q;
    logic [31:0]             hrdata_q;

    logic [4:0]              op;
    logic [15:0]             cc_vec;
    logic                    cond_true;
    logic                    uncond;
    logic                    take;
    logic                    in_exec;
    logic [PTR_W-1:0]        ptr_next;
    logic [PTR_W-1:0]        stack_top;
    logic                    push;
    logic                    pop;
    logic                    push_drop;
    logic                    pop_drop;
    logic                    start_pulse;
    logic                    delay_done;
    logic                    cmp_lt;
    logic                    cmp_eq;
    logic [INT_W-1:0]        int_set;
    logic [INT_W-1:0]        int_clr;
    logic                    rd_take;
    logic [ADDR_W-1:0]       raddr;

    // Per-flag two-bit control: 00 keep, 01 set, 10 clear, 11 invert
    function automatic logic [7:0] flag_update(input logic [7:0] cur, input logic [WORD_W-1:0] prm);
        logic [7:0] res;
        res = cur;
        for (int n = 0; n < 8; n++) begin
            unique case ({prm[n+8], prm[n]})
                2'b00: res[n] = cur[n];
                2'b01: res[n] = 1'b1;
                2'b10: res[n] = 1'b0;
                2'b11: res[n] = ~cur[n];
            endcase
        end
        return res;
    endfunction

    function automatic logic is_ram(input logic [ADDR_W-1:0] a);
        return a >= RAM_BASE;
    endfunction

    // Instruction decode
    assign op        = opw_q[OPC_MSB:OPC_LSB];
    assign cc_vec    = {msg_cond_i, gp_q};
    assign cond_true = cc_vec[opw_q[CC_SEL_MSB:0]] == opw_q[CC_SENSE];
    assign uncond    = (op == OP_FRCMP) || (op == OP_MSGCMP) || (op == OP_FLAGUPD);
    assign take      = uncond || cond_true;
    assign in_exec   = (state_q == S_EXEC);
    assign ptr_next  = ptr_q + PTR_STEP;
    assign stack_top = stack_q[2'(depth_q - 3'd1)];
    assign push      = in_exec && take && (op == OP_CALL) && (depth_q < 3'(STACK_DEPTH));
    assign push_drop = in_exec && take && (op == OP_CALL) && (depth_q == 3'(STACK_DEPTH));
    assign pop       = in_exec && take && (op == OP_RETURN) && (depth_q != 3'd0);
    assign pop_drop  = in_exec && take && (op == OP_RETURN) && (depth_q == 3'd0);
    assign delay_done = (tnm_q == 16'h0000);
    assign cmp_lt    = prm_q < frame_time_i;
    assign cmp_eq    = prm_q == frame_time_i;

    // Bus side decode
    assign start_pulse = wr_q && (waddr_q == OFF_CTRL) && hwdata[0];
    assign int_clr     = (wr_q && (waddr_q == OFF_INT_STAT)) ? hwdata[INT_W-1:0] : '0;
    assign rd_take     = hsel && hready && htrans[1] && !hwrite;
    assign raddr       = haddr[ADDR_W-1:0];

    always_comb begin
        int_set = '0;
        if (in_exec && take && (op == OP_IRQ)) begin
            int_set[INT_SEQ_LSB +: IRQ_PAT_W] = prm_q[IRQ_PAT_W-1:0];
        end
        int_set[INT_STACK] = push_drop || pop_drop;
        int_set[INT_STOP]  = in_exec && take && (op == OP_STOP);
    end

    // Sequencer control
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q   <= S_IDLE;
            ptr_q     <= '0;
            opw_q     <= '0;
            prm_q     <= '0;
            stopped_q <= 1'b0;
        end else if (ce) begin
            if (start_pulse) begin
                state_q   <= S_FETCH_OP;
                ptr_q     <= start_addr_q;
                stopped_q <= 1'b0;
            end else begin
                unique case (state_q)
                    S_IDLE: begin
                        state_q <= S_IDLE;
                    end
                    S_FETCH_OP: begin
                        opw_q   <= ram_q[ptr_q];
                        state_q <= S_FETCH_PRM;
                    end
                    S_FETCH_PRM: begin
                        prm_q   <= ram_q[PTR_W'(ptr_q + 6'h01)];
                        state_q <= S_EXEC;
                    end
                    S_EXEC: begin
                        state_q <= S_FETCH_OP;
                        ptr_q   <= ptr_next;
                        if (take) begin
                            unique case (op)
                                OP_CALL: ptr_q <= prm_q[PTR_W-1:0];
                                OP_RETURN: ptr_q <= pop ? stack_top : ptr_next;
                                OP_STOP: begin
                                    state_q   <= S_IDLE;
                                    stopped_q <= 1'b1;
                                end
                                OP_PAUSE: begin
                                    if (prm_q != 16'h0000) begin
                                        state_q <= S_DELAY;
                                        ptr_q   <= ptr_q;
                                    end
                                end
                                OP_FRWAIT: begin
                                    state_q <= S_FRWAIT;
                                    ptr_q   <= ptr_q;
                                end
                                default: ptr_q <= ptr_next;
                            endcase
                        end
                    end
                    S_DELAY: begin
                        if (delay_done) begin
                            state_q <= S_FETCH_OP;
                            ptr_q   <= ptr_next;
                        end
                    end
                    S_FRWAIT: begin
                        if (frame_time_i == 16'h0000) begin
                            state_q <= S_FETCH_OP;
                            ptr_q   <= ptr_next;
                        end
                    end
                endcase
            end
        end
    end

    // Call stack
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            depth_q <= '0;
            for (int i = 0; i < STACK_DEPTH; i++) begin
                stack_q[i] <= '0;
            end
        end else if (ce) begin
            if (start_pulse) begin
                depth_q <= '0;
            end else if (push) begin
                stack_q[depth_q[1:0]] <= ptr_next;
                depth_q               <= depth_q + 3'd1;
            end else if (pop) begin
                depth_q <= depth_q - 3'd1;
            end
        end
    end

    // Time-to-next-message timer, shared by the pause instruction
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tnm_q <= '0;
            pre_q <= '0;
        end else if (ce) begin
            if (in_exec && take && (op == OP_PAUSE)) begin
                tnm_q <= prm_q;
                pre_q <= '0;
            end else if ((state_q == S_DELAY) && !delay_done) begin
                if (pre_q == PRE_LAST) begin
                    pre_q <= '0;
                    tnm_q <= tnm_q - 16'h0001;
                end else begin
                    pre_q <= pre_q + 8'h01;
                end
            end
        end
    end

    // General-purpose condition flags
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            gp_q <= '0;
        end else if (ce && in_exec) begin
            unique case (op)
                OP_FRCMP, OP_MSGCMP: begin
                    gp_q[0] <= cmp_lt;
                    gp_q[1] <= cmp_eq;
                end
                OP_FLAGUPD: gp_q <= flag_update(gp_q, prm_q);
                default: gp_q <= gp_q;
            endcase
        end
    end

    // Interrupt status, mask and output; a set wins over a clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            int_stat_q <= '0;
            irq_q      <= 1'b0;
        end else if (ce) begin
            int_stat_q <= (int_stat_q & ~int_clr) | int_set;
            irq_q      <= |(int_stat_q & int_mask_q);
        end
    end

    // Host registers and bus address phase
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_q         <= 1'b0;
            waddr_q      <= '0;
            int_mask_q   <= INT_MASK_RST;
            start_addr_q <= START_RST;
            hrdata_q     <= '0;
        end else if (ce) begin
            wr_q    <= hsel && hready && htrans[1] && hwrite;
            waddr_q <= raddr;
            if (wr_q && (waddr_q == OFF_INT_MASK)) begin
                int_mask_q <= hwdata[INT_W-1:0];
            end
            if (wr_q && (waddr_q == OFF_START)) begin
                start_addr_q <= hwdata[PTR_W-1:0];
            end
            if (rd_take) begin
                hrdata_q <= '0;
                if (is_ram(raddr)) begin
                    hrdata_q[WORD_W-1:0] <= ram_q[raddr[PTR_W+1:2]];
                end else begin
                    unique case (raddr)
                        OFF_STATUS: begin
                            hrdata_q[ST_RUN]               <= (state_q != S_IDLE);
                            hrdata_q[ST_STOP]              <= stopped_q;
                            hrdata_q[ST_WAIT]              <= (state_q == S_DELAY) || (state_q == S_FRWAIT);
                            hrdata_q[ST_DEPTH +: DEPTH_W]  <= depth_q;
                            hrdata_q[ST_PTR +: PTR_W]      <= ptr_q;
                        end
                        OFF_INT_STAT: hrdata_q[INT_W-1:0] <= int_stat_q;
                        OFF_INT_MASK: hrdata_q[INT_W-1:0] <= int_mask_q;
                        OFF_GPFLAGS:  hrdata_q[7:0]       <= gp_q;
                        OFF_START:    hrdata_q[PTR_W-1:0] <= start_addr_q;
                        default:      hrdata_q            <= '0;
                    endcase
                end
            end
        end
    end

    // Instruction list memory, written by the host only
    always_ff @(posedge clk) begin
        if (ce && wr_q && is_ram(waddr_q)) begin
            ram_q[waddr_q[PTR_W+1:2]] <= hwdata[WORD_W-1:0];
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;
    assign irq       = irq_q;

    // Checks
    default clocking cb @(posedge clk iff ce);
    endclocking
    default disable iff (!rst_n);

    sequence s_exec_taken(logic [4:0] code);
        in_exec && take && (op == code) && !start_pulse;
    endsequence

    property p_skip_false;
        in_exec && !take && !start_pulse |=> (state_q == S_FETCH_OP) && (ptr_q == $past(ptr_next));
    endproperty
    a_skip_false: assert property (p_skip_false) else $error("false condition did not skip");

    property p_call;
        s_exec_taken(OP_CALL) ##0 (depth_q < 3'd4) |=>
            (ptr_q == $past(prm_q[PTR_W-1:0])) && (depth_q == $past(depth_q) + 3'd1);
    endproperty
    a_call: assert property (p_call) else $error("call did not jump and push");

    property p_depth_max;
        depth_q <= 3'd4;
    endproperty
    a_depth_max: assert property (p_depth_max) else $error("call stack deeper than four");

    property p_return;
        s_exec_taken(OP_RETURN) ##0 (depth_q != 3'd0) |=> (ptr_q == $past(stack_top));
    endproperty
    a_return: assert property (p_return) else $error("return went to wrong address");

    property p_irq_set;
        s_exec_taken(OP_IRQ) |=> ((int_stat_q[5:2] & $past(prm_q[3:0])) == $past(prm_q[3:0]));
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("interrupt pattern not set");

    property p_irq_zero;
        s_exec_taken(OP_IRQ) ##0 (prm_q[3:0] == 4'h0) |=> ((int_stat_q[5:2] & ~$past(int_stat_q[5:2])) == 4'h0);
    endproperty
    a_irq_zero: assert property (p_irq_zero) else $error("zero pattern set a bit");

    property p_stop_hold;
        (state_q == S_IDLE) && stopped_q && !start_pulse |=> (state_q == S_IDLE);
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("stopped sequencer resumed without start");

    property p_pause;
        s_exec_taken(OP_PAUSE) ##0 (prm_q != 16'h0000) ##1 !start_pulse [*8] |-> (state_q == S_DELAY);
    endproperty
    a_pause: assert property (p_pause) else $error("pause ended too early");

    property p_frame_wait;
        (state_q == S_FRWAIT) && (frame_time_i != 16'h0000) && !start_pulse |=> (state_q == S_FRWAIT);
    endproperty
    a_frame_wait: assert property (p_frame_wait) else $error("frame wait left early");

    property p_compare;
        in_exec && ((op == OP_FRCMP) || (op == OP_MSGCMP)) |=>
            (gp_q[0] == $past(cmp_lt)) && (gp_q[1] == $past(cmp_eq)) && (gp_q[7:2] == $past(gp_q[7:2]));
    endproperty
    a_compare: assert property (p_compare) else $error("compare flags wrong");

    property p_flag_update;
        in_exec && (op == OP_FLAGUPD) |=> (gp_q == flag_update($past(gp_q), $past(prm_q)));
    endproperty
    a_flag_update: assert property (p_flag_update) else $error("flag update wrong");

endmodule

/* File: bsf_testbench.sv */
// Self-checking testbench for the sequencer flow-op engine
`timescale 1ns/100ps
module testbench;
    import bsf_pkg::*;
    logic        clk, rst_n, ce, hsel, hwrite, hreadyout, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [15:0] frame_time_i;
    logic [7:0]  msg_cond_i;
    int          bad_count, num_checks;

    bsf_sequencer i_bsf_sequencer (.clk(clk), .rst_n(rst_n), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .frame_time_i(frame_time_i),
        .msg_cond_i(msg_cond_i), .irq(irq));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic give_verdict();
        if (bad_count == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Waits for an edge that samples hready high, bounded
    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge clk);
        while (hreadyout !== 1'b1 && n < 50) begin
            n++;
            @(posedge clk);
        end
        if (n >= 50) begin
            check("hready", 32'h1, 32'h0);
        end
    endtask

    task automatic ahb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= 32'(a);
        htrans <= 2'b10;
        hwrite <= wr;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
        check("hresp", 32'h0, 32'(hresp));
    endtask

    task automatic rdchk(input string what, input logic [ADDR_W-1:0] a, input logic [31:0] m,
                         input logic [31:0] exp);
        ahb(1'b0, a, 32'h0);
        check(what, exp, rd & m);
    endtask

    task automatic put(input int idx, input logic [15:0] op, input logic [15:0] prm);
        ahb(1'b1, RAM_BASE + ADDR_W'(4 * idx), {16'h0, op});
        ahb(1'b1, RAM_BASE + ADDR_W'(4 * idx + 4), {16'h0, prm});
    endtask

    task automatic go(input int idx);
        ahb(1'b1, OFF_START, 32'(idx));
        ahb(1'b1, OFF_CTRL, 32'h1);
    endtask

    task automatic test_reset();
        rdchk("int_stat", OFF_INT_STAT, 32'hFFFF_FFFF, 32'h0);
        rdchk("gpflags", OFF_GPFLAGS, 32'hFFFF_FFFF, 32'h0);
        rdchk("status", OFF_STATUS, 32'h0000_0077, 32'h0);
        ahb(1'b1, 9'h018, 32'hFFFF_FFFF);
        rdchk("unmapped", 9'h018, 32'hFFFF_FFFF, 32'h0);
        check("irq_rst", 32'h0, 32'(irq));
        ce <= 1'b0;
        ahb(1'b1, OFF_INT_MASK, 32'h0000_003F);
        ce <= 1'b1;
        rdchk("ce_frozen", OFF_INT_MASK, 32'h0000_003F, 32'h0);
    endtask

    task automatic test_flags_irq();
        put(0, 16'h3000, 16'h00FF);
        put(2, 16'h3000, 16'hF0A5);
        put(4, 16'h1817, 16'h000F);
        put(6, 16'h1810, 16'hFFF5);
        put(8, 16'h1810, 16'hFFF0);
        put(10, 16'h2817, 16'h000F);
        put(12, 16'h2C17, 16'h0010);
        put(14, 16'h1C18, 16'h0000);
        rdchk("ram_rd", RAM_BASE + 9'h004, 32'hFFFF_FFFF, 32'h0000_00FF);
        frame_time_i <= 16'h0010;
        msg_cond_i   <= 8'h01;
        go(0);
        repeat (40) @(posedge clk);
        rdchk("gpflags", OFF_GPFLAGS, 32'h0000_00FF, 32'h0000_000E);
        rdchk("int_stat", OFF_INT_STAT, 32'h0000_003F, 32'h0000_0016);
        rdchk("status_stop", OFF_STATUS, 32'h0000_0003, 32'h0000_0002);
        check("irq_masked", 32'h0, 32'(irq));
        ahb(1'b1, OFF_INT_MASK, 32'h0000_0004);
        repeat (2) @(posedge clk);
        check("irq_on", 32'h1, 32'(irq));
        ahb(1'b1, OFF_INT_STAT, 32'h0000_0016);
        repeat (2) @(posedge clk);
        check("irq_off", 32'h0, 32'(irq));
        rdchk("int_clr", OFF_INT_STAT, 32'h0000_003F, 32'h0);
        ahb(1'b1, OFF_INT_MASK, 32'h0);
    endtask

    task automatic test_flag_compare();
        put(16, 16'h3000, 16'h00FF);
        put(18, 16'h3000, 16'hF0A5);
        put(20, 16'h1817, 16'h000F);
        put(22, 16'h2817, 16'h000F);
        put(24, 16'h1C18, 16'h0000);
        go(16);
        repeat (30) @(posedge clk);
        rdchk("gp_cmp_lt", OFF_GPFLAGS, 32'h0000_00FF, 32'h0000_000D);
        rdchk("irq_skip", OFF_INT_STAT, 32'h0000_003C, 32'h0);
    endtask

    task automatic test_call_pause();
        put(24, 16'h0C10, 16'h001E);
        put(26, 16'h1C18, 16'h0000);
        put(30, 16'h2410, 16'h0000);
        put(32, 16'h2010, 16'h0002);
        put(34, 16'h1010, 16'h1234);
        ahb(1'b1, OFF_INT_STAT, 32'h0000_003F);
        frame_time_i <= 16'h0005;
        go(24);
        repeat (100) @(posedge clk);
        rdchk("frame_wait", OFF_STATUS, 32'h0000_0077, 32'h0000_0015);
        frame_time_i <= 16'h0000;
        repeat (300) @(posedge clk);
        rdchk("pausing", OFF_STATUS, 32'h0000_0077, 32'h0000_0015);
        repeat (150) @(posedge clk);
        rdchk("returned", OFF_STATUS, 32'h0000_0077, 32'h0000_0002);
        rdchk("no_err", OFF_INT_STAT, 32'h0000_003F, 32'h0000_0002);
    endtask

    task automatic test_stack();
        put(40, 16'h0C10, 16'h0028);
        put(44, 16'h1010, 16'h0000);
        put(46, 16'h1C18, 16'h0000);
        ahb(1'b1, OFF_INT_STAT, 32'h0000_003F);
        go(40);
        repeat (60) @(posedge clk);
        rdchk("depth4", OFF_STATUS, 32'h0000_0071, 32'h0000_0041);
        rdchk("push_full", OFF_INT_STAT, 32'h0000_0001, 32'h0000_0001);
        go(46);
        repeat (10) @(posedge clk);
        ahb(1'b1, OFF_INT_STAT, 32'h0000_003F);
        go(44);
        repeat (20) @(posedge clk);
        rdchk("pop_empty", OFF_INT_STAT, 32'h0000_003F, 32'h0000_0003);
        rdchk("stopped", OFF_STATUS, 32'h0000_0073, 32'h0000_0002);
    endtask

    initial begin
        bad_count    = 0;
        num_checks   = 0;
        rst_n        = 1'b0;
        ce           = 1'b1;
        hsel         = 1'b0;
        haddr        = 32'h0;
        htrans       = 2'b00;
        hwrite       = 1'b0;
        hsize        = 3'h2;
        hwdata       = 32'h0;
        frame_time_i = 16'h0;
        msg_cond_i   = 8'h0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        test_reset();
        test_flags_irq();
        test_flag_compare();
        test_call_pause();
        test_stack();
        give_verdict();
    end

    // Watchdog against a hung handshake or sequence
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        give_verdict();
    end
endmodule
